// file: design/pscr_pkg.sv
// Purpose: shared constants and types of the system control register bank
// Assumes: 100 MHz clk_sys, one clock domain
// Notes: times are held in their own unit, cycle counts are derived
package pscr_pkg;
  // register offsets on the host register port
  localparam logic [8:0] OFS_SEQ = 9'h010;
  localparam logic [8:0] OFS_IND = 9'h011;
  localparam logic [8:0] OFS_LOCK = 9'h012;
  localparam logic [8:0] OFS_CMD = 9'h013;
  localparam logic [8:0] OFS_PDD = 9'h014;
  // window guarded by the voltage lock
  localparam logic [8:0] LOCK_LO = 9'h081;
  localparam logic [8:0] LOCK_HI = 9'h120;
  // reset values
  localparam logic [7:0] RST_SEQ = 8'h00;
  localparam logic [7:0] RST_IND = 8'h00;
  localparam logic [7:0] RST_LOCK = 8'h00;
  localparam logic [7:0] RST_CMD = 8'h00;
  localparam logic [7:0] RST_PDD = 8'h00;
  // writable bits; the rest are reserved and read zero
  localparam logic [7:0] WMASK_LOCK = 8'hf8;
  localparam logic [7:0] WMASK_CMD = 8'h07;
  localparam logic [7:0] WMASK_PDD = 8'h8b;
  // field positions
  localparam int SEQ_DEFAULT_SUPPLY_SELECT = 7;
  localparam int SEQ_RAMP_LSB = 5;
  localparam int SEQ_RELOAD = 4;
  localparam int SEQ_AUTO_BOOT = 3;
  localparam int SEQ_FILTER_LSB = 0;
  localparam int IND_ONTIME_LSB = 6;
  localparam int IND_FREQ_LSB = 3;
  localparam int IND_WDSCALE_LSB = 0;
  localparam int LOCK_VLOCK = 7;
  localparam int LOCK_FB2 = 6;
  localparam int LOCK_FB3 = 5;
  localparam int LOCK_ECO = 3;
  localparam int CMD_WAKE = 2;
  localparam int CMD_SHUT = 1;
  localparam int CMD_WDOG = 0;
  localparam int PDD_PORTS = 7;
  localparam int PDD_TWO_WIRE = 3;
  localparam int PDD_ADC = 1;
  localparam int PDD_GPI = 0;
  // timing
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 100000;
  localparam int RAMP_BASE_NS = 500;
  localparam logic [8:0] RAMP_BASE_CYC = 9'((RAMP_BASE_NS + CLK_NS - 1) / CLK_NS);
  // filter times in 0.1 ms ticks, codes 7 down to 0
  localparam logic [7:0][13:0] FILTER_TICKS = {14'd10240, 14'd5120, 14'd2560, 14'd512,
                                               14'd102, 14'd10, 14'd1, 14'd0};
  // flash periods in ticks: 180 ms, 4 s, 2 s, 1 s
  localparam logic [3:0][15:0] FLASH_PERIOD = {16'd1800, 16'd40000, 16'd20000, 16'd10000};
  // flash on-times in ticks: 20 ms double, 40, 20, 10 ms
  localparam logic [3:0][15:0] FLASH_ON = {16'd200, 16'd400, 16'd200, 16'd100};
  localparam logic [15:0] FLASH_SECOND_ON = 16'd400;
  localparam logic [17:0] WAKE_CLR_TICKS = 18'd160000;
  localparam logic [19:0] RES_FLASH_TICKS = 20'd600000;

  // operating mode reported by the sequencer
  typedef enum logic [1:0] {MODE_RESET, MODE_POWER_DOWN_MODE, MODE_ACTIVE, MODE_OTHER} pscr_mode_t;

  // one access from the serial interface front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } pscr_req_t;

  // power-down controls handed to the steered units
  typedef struct packed {
    logic domain_ports_en;
    logic domain_force_detect;
    logic two_wire_en;
    logic converter_pause;
    logic input_pins_en;
    logic input_force_detect;
  } pscr_pd_t;
endpackage

// file: design/pscr_top.sv
// Purpose: five system control registers and the logic they steer directly
// Assumes: host port and sequencer signals are on clk_sys; pins are asynchronous
// Notes: one clock, synchronous reset, all outputs registered
module pscr_top #(
  parameter int TICK_CYC = pscr_pkg::TICK_NS / pscr_pkg::CLK_NS // cycles per 0.1 ms tick
) (
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire pscr_pkg::pscr_req_t host_req, // register access
  output logic [7:0] host_rdata, // read data, one cycle after rd
  output logic write_refused, // pulse: locked write refused
  input wire pscr_pkg::pscr_mode_t op_mode, // sequencer mode
  input wire logic slot_zero_entry, // pulse: sequencer enters slot 0
  input wire logic wakeup_event, // pulse: valid wakeup
  input wire logic ramp_active, // a voltage ramp is running
  input wire logic pd_step_in_range, // disable step above 1 and within max
  input wire logic pd_step_reached, // pulse: disable step processed
  input wire logic flash_code_from_otp, // flash code came from defaults
  input wire logic reset_flash_enable, // reset flashing allowed
  input wire logic power_good_status, // supervised regulators good
  input wire logic power_key_pin, // raw power key pin
  input wire logic shutdown_pin, // raw shutdown pin
  input wire logic gpi_pin, // raw general input pin
  input wire logic charger_wake_pin, // raw charger wake pin
  input wire logic vdd_start_pin, // raw supply start pin
  input wire logic fb3_pin, // feedback pin three, brake input
  input wire logic fb2_in, // feedback pin two, pad level
  output logic fb2_out, // feedback pin two, drive level
  output logic fb2_oe, // feedback pin two, drive enable
  output logic default_supply_apply, // pulse: apply default supply modes
  output logic ramp_step, // pulse: one 10 mV ramp step
  output logic reload_request, // pulse: reload programmed config
  output logic sequencer_start, // pulse: start power sequencer
  output logic power_key_input, // filtered power key
  output logic shutdown_input, // filtered shutdown input
  output logic gpi_level, // filtered general input
  output logic flash_override, // flashing owns the indicators
  output logic indicator_output_a, // indicator a flash level
  output logic indicator_output_b, // indicator b flash level
  output logic watchdog_enable, // watchdog running
  output logic [6:0] watchdog_scale, // period multiplier
  output logic watchdog_restart, // pulse: restart watchdog
  output logic motor_stop, // brake asserted
  output logic keep_active_input, // watchdog keep-active
  output logic pulsed_mode_arm, // pulsed mode armed
  output logic wake_request, // wake command pending
  output logic shutdown_request, // shutdown command pending
  output pscr_pkg::pscr_pd_t pd_ctl // power-down controls
);
  import pscr_pkg::*;

  localparam int P_KEY = 0;
  localparam int P_SHUT = 1;
  localparam int P_GPI = 2;
  localparam int P_CHG = 3;
  localparam int P_VDD = 4;
  localparam int P_FB3 = 5;
  localparam int P_FB2 = 6;

  typedef enum logic {FL_IDLE, FL_RUN} pscr_flash_t;

  // ramp step interval grows as the code falls
  function automatic logic [8:0] ramp_limit(input logic [1:0] code);
    ramp_limit = 9'(RAMP_BASE_CYC << (2'd3 - code));
  endfunction

  // flash codes 5..7 reuse the periods of codes 2..4
  function automatic logic [1:0] flash_idx(input logic [2:0] code);
    flash_idx = (code <= 3'h4) ? 2'(code - 3'h1) : 2'(code - 3'h4);
  endfunction

  logic [7:0] seq_cfg, ind_cfg, lock_cfg, cmd, pdd; // register contents
  logic [7:0] next_seq_cfg, next_ind_cfg, next_lock_cfg, next_cmd, next_pdd;
  logic [7:0] next_host_rdata;
  logic next_write_refused;
  logic [6:0] s1, s2, s3; // pin synchronisers; s1 only feeds s2
  logic [6:0] pin_lvl, next_pin_lvl; // agreed pin levels
  logic [31:0] tick_cnt, next_tick_cnt; // 0.1 ms prescaler
  logic tick, next_tick;
  logic [2:0][13:0] flt_cnt, next_flt_cnt; // debounce counters
  logic [2:0] flt_out, next_flt_out;
  logic [8:0] ramp_cnt, next_ramp_cnt;
  logic next_ramp_step;
  pscr_flash_t fl_state, next_fl_state;
  logic [15:0] fl_cnt, next_fl_cnt; // position within flash period
  logic [19:0] res_cnt, next_res_cnt; // reset flashing time used
  logic next_flash_override, next_ind;
  logic [17:0] wake_cnt, next_wake_cnt;
  pscr_mode_t mode_q; // mode of last cycle, for edges
  logic boot_wait, next_boot_wait;
  logic step_done, next_step_done;
  logic next_default_supply_apply, next_reload_request, next_sequencer_start;
  logic next_pulsed_mode_arm, next_motor_stop, next_keep_active;
  logic next_fb2_out, next_fb2_oe, next_wd_en;
  logic [6:0] next_wd_scale;
  pscr_pd_t next_pd_ctl;

  // mode edge decode
  logic enter_reset, leave_reset, leave_pd, in_pd, pd_go, wr_ok;
  assign enter_reset = (op_mode == MODE_RESET) && (mode_q != MODE_RESET);
  assign leave_reset = (op_mode != MODE_RESET) && (mode_q == MODE_RESET);
  assign leave_pd = (op_mode != MODE_POWER_DOWN_MODE) && (mode_q == MODE_POWER_DOWN_MODE);
  assign in_pd = (op_mode == MODE_POWER_DOWN_MODE);
  assign pd_go = in_pd && (!pd_step_in_range || step_done);
  assign wr_ok = host_req.wr;

  // register file next values
  always_comb begin
    next_seq_cfg = seq_cfg;
    next_ind_cfg = ind_cfg;
    next_lock_cfg = lock_cfg;
    next_pdd = pdd;
    next_cmd = cmd;
    next_host_rdata = host_rdata;
    next_cmd[CMD_WDOG] = 1'b0;
    // wake clears 16 s into active mode
    if (wake_cnt >= WAKE_CLR_TICKS) begin
      next_cmd[CMD_WAKE] = 1'b0;
    end
    if (enter_reset) begin
      next_cmd[CMD_SHUT] = 1'b0;
    end
    // lock refuses the guarded window; none of ours lie in it
    next_write_refused = host_req.wr && lock_cfg[LOCK_VLOCK]
                         && (host_req.addr >= LOCK_LO) && (host_req.addr <= LOCK_HI);
    if (wr_ok) begin
      unique case (host_req.addr)
        OFS_SEQ: next_seq_cfg = host_req.wdata;
        OFS_IND: next_ind_cfg = host_req.wdata;
        OFS_LOCK: next_lock_cfg = host_req.wdata & WMASK_LOCK;
        OFS_PDD: next_pdd = host_req.wdata & WMASK_PDD;
        // only ones act; set wins over self-clear
        OFS_CMD: next_cmd = next_cmd | (host_req.wdata & WMASK_CMD);
        default: ;
      endcase
    end
    if (host_req.rd) begin
      unique case (host_req.addr)
        OFS_SEQ: next_host_rdata = seq_cfg;
        OFS_IND: next_host_rdata = ind_cfg;
        OFS_LOCK: next_host_rdata = lock_cfg;
        OFS_CMD: next_host_rdata = cmd;
        OFS_PDD: next_host_rdata = pdd;
        default: next_host_rdata = 8'h00;
      endcase
    end
  end

  // register file storage
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      seq_cfg <= RST_SEQ;
      ind_cfg <= RST_IND;
      lock_cfg <= RST_LOCK;
      cmd <= RST_CMD;
      pdd <= RST_PDD;
      host_rdata <= 8'h00;
      write_refused <= 1'b0;
    end else begin
      seq_cfg <= next_seq_cfg;
      ind_cfg <= next_ind_cfg;
      lock_cfg <= next_lock_cfg;
      cmd <= next_cmd;
      pdd <= next_pdd;
      host_rdata <= next_host_rdata;
      write_refused <= next_write_refused;
    end
  end

  // pin agreement, prescaler, debounce and ramp pacing
  always_comb begin
    next_pin_lvl = pin_lvl;
    for (int i = 0; i < 7; i++) begin
      // a change counts once stages two and three agree
      if (s2[i] == s3[i]) begin
        next_pin_lvl[i] = s3[i];
      end
    end
    next_tick = (tick_cnt == 32'(TICK_CYC - 1));
    next_tick_cnt = next_tick ? 32'h0 : tick_cnt + 32'h1;
    next_flt_cnt = flt_cnt;
    next_flt_out = flt_out;
    for (int i = 0; i < 3; i++) begin
      if (seq_cfg[SEQ_FILTER_LSB +: 3] == 3'h0 || pin_lvl[i] == flt_out[i]) begin
        next_flt_out[i] = pin_lvl[i];
        next_flt_cnt[i] = 14'h0;
      end else if (tick) begin
        // flipping one tick late keeps the filter time a minimum
        if (flt_cnt[i] >= FILTER_TICKS[seq_cfg[SEQ_FILTER_LSB +: 3]]) begin
          next_flt_out[i] = pin_lvl[i];
          next_flt_cnt[i] = 14'h0;
        end else begin
          next_flt_cnt[i] = flt_cnt[i] + 14'h1;
        end
      end
    end
    // one step per interval while ramping
    next_ramp_step = 1'b0;
    next_ramp_cnt = 9'h0;
    if (ramp_active) begin
      if (ramp_cnt >= ramp_limit(seq_cfg[SEQ_RAMP_LSB +: 2]) - 9'h1) begin
        next_ramp_step = 1'b1;
      end else begin
        next_ramp_cnt = ramp_cnt + 9'h1;
      end
    end
  end

  // synchronisers and timers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1 <= 7'h00;
      s2 <= 7'h00;
      s3 <= 7'h00;
      pin_lvl <= 7'h00;
      tick_cnt <= 32'h0;
      tick <= 1'b0;
      flt_cnt <= '0;
      flt_out <= 3'h0;
      ramp_cnt <= 9'h0;
      ramp_step <= 1'b0;
    end else begin
      s1 <= {fb2_in, fb3_pin, vdd_start_pin, charger_wake_pin, gpi_pin, shutdown_pin,
             power_key_pin};
      s2 <= s1;
      s3 <= s2;
      pin_lvl <= next_pin_lvl;
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
      flt_cnt <= next_flt_cnt;
      flt_out <= next_flt_out;
      ramp_cnt <= next_ramp_cnt;
      ramp_step <= next_ramp_step;
    end
  end

  // indicator flashing
  always_comb begin
    logic [2:0] frq;
    logic [1:0] dur;
    logic allow;
    frq = ind_cfg[IND_FREQ_LSB +: 3];
    dur = ind_cfg[IND_ONTIME_LSB +: 2];
    allow = 1'b0;
    next_res_cnt = res_cnt;
    if (frq >= 3'h5) begin
      // limited by the reset flashing budget
      allow = pin_lvl[P_VDD] && reset_flash_enable && (res_cnt < RES_FLASH_TICKS);
      if (!pin_lvl[P_VDD]) begin
        next_res_cnt = 20'h0;
      end else if (allow && tick) begin
        next_res_cnt = res_cnt + 20'h1;
      end
    end else if (frq != 3'h0) begin
      allow = !flash_code_from_otp || pin_lvl[P_CHG];
    end
    // code zero hands outputs back to mode
    next_flash_override = (frq != 3'h0);
    next_fl_state = fl_state;
    next_fl_cnt = fl_cnt;
    next_ind = 1'b0;
    unique case (fl_state)
      FL_IDLE: begin
        next_fl_cnt = 16'h0;
        if (allow) begin
          next_fl_state = FL_RUN;
        end
      end
      FL_RUN: begin
        if (!allow) begin
          next_fl_state = FL_IDLE;
        end else if (tick) begin
          next_fl_cnt = (fl_cnt >= FLASH_PERIOD[flash_idx(frq)] - 16'h1) ? 16'h0
                        : fl_cnt + 16'h1;
        end
        // on-time window, second stroke for code 3
        next_ind = allow && ((fl_cnt < FLASH_ON[dur]) || (dur == 2'h3
                   && fl_cnt >= FLASH_SECOND_ON && fl_cnt < FLASH_SECOND_ON + FLASH_ON[dur]));
      end
    endcase
  end

  // flash state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fl_state <= FL_IDLE;
      fl_cnt <= 16'h0;
      res_cnt <= 20'h0;
      flash_override <= 1'b0;
      indicator_output_a <= 1'b0;
      indicator_output_b <= 1'b0;
    end else begin
      fl_state <= next_fl_state;
      fl_cnt <= next_fl_cnt;
      res_cnt <= next_res_cnt;
      flash_override <= next_flash_override;
      indicator_output_a <= next_ind;
      indicator_output_b <= next_ind;
    end
  end

  // sequencing, pins and power-down controls
  always_comb begin
    // defaults applied on slot zero entry
    next_default_supply_apply = slot_zero_entry && seq_cfg[SEQ_DEFAULT_SUPPLY_SELECT];
    next_reload_request = leave_pd && seq_cfg[SEQ_RELOAD];
    // auto start or wait for a wakeup
    next_sequencer_start = 1'b0;
    next_boot_wait = boot_wait;
    if (leave_reset) begin
      next_sequencer_start = seq_cfg[SEQ_AUTO_BOOT];
      next_boot_wait = !seq_cfg[SEQ_AUTO_BOOT];
    end else if (boot_wait && wakeup_event) begin
      next_sequencer_start = 1'b1;
      next_boot_wait = 1'b0;
    end
    // arm pulsed mode on reset entry
    next_pulsed_mode_arm = pulsed_mode_arm;
    if (enter_reset) begin
      next_pulsed_mode_arm = lock_cfg[LOCK_ECO];
    end else if (op_mode != MODE_RESET) begin
      next_pulsed_mode_arm = 1'b0;
    end
    // count active time while wake is set
    next_wake_cnt = 18'h0;
    if (cmd[CMD_WAKE] && op_mode == MODE_ACTIVE && wake_cnt < WAKE_CLR_TICKS) begin
      next_wake_cnt = wake_cnt + (tick ? 18'h1 : 18'h0);
    end
    next_motor_stop = lock_cfg[LOCK_FB3] && !pin_lvl[P_FB3];
    next_fb2_oe = !lock_cfg[LOCK_FB2];
    next_fb2_out = !lock_cfg[LOCK_FB2] && power_good_status;
    next_keep_active = lock_cfg[LOCK_FB2] && pin_lvl[P_FB2];
    next_wd_en = (ind_cfg[IND_WDSCALE_LSB +: 3] != 3'h0);
    next_wd_scale = next_wd_en ? 7'(7'h01 << (ind_cfg[IND_WDSCALE_LSB +: 3] - 3'h1)) : 7'h00;
    next_step_done = in_pd && (step_done || pd_step_reached);
    // domain ports off, detect on re-enable
    next_pd_ctl.domain_ports_en = !(pdd[PDD_PORTS] && pd_go);
    next_pd_ctl.domain_force_detect = next_pd_ctl.domain_ports_en && !pd_ctl.domain_ports_en;
    next_pd_ctl.two_wire_en = !(pdd[PDD_TWO_WIRE] && pd_go);
    next_pd_ctl.converter_pause = pdd[PDD_ADC] && pd_go;
    // input pins off, detect on re-enable
    next_pd_ctl.input_pins_en = !(pdd[PDD_GPI] && pd_go);
    next_pd_ctl.input_force_detect = next_pd_ctl.input_pins_en && !pd_ctl.input_pins_en;
  end

  // sequencing and control outputs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_q <= MODE_RESET;
      boot_wait <= 1'b0;
      step_done <= 1'b0;
      wake_cnt <= 18'h0;
      default_supply_apply <= 1'b0;
      reload_request <= 1'b0;
      sequencer_start <= 1'b0;
      pulsed_mode_arm <= 1'b0;
      motor_stop <= 1'b0;
      fb2_oe <= 1'b0;
      fb2_out <= 1'b0;
      keep_active_input <= 1'b0;
      watchdog_enable <= 1'b0;
      watchdog_scale <= 7'h00;
      pd_ctl <= '{domain_ports_en: 1'b1, domain_force_detect: 1'b0, two_wire_en: 1'b1,
                  converter_pause: 1'b0, input_pins_en: 1'b1, input_force_detect: 1'b0};
    end else begin
      mode_q <= op_mode;
      boot_wait <= next_boot_wait;
      step_done <= next_step_done;
      wake_cnt <= next_wake_cnt;
      default_supply_apply <= next_default_supply_apply;
      reload_request <= next_reload_request;
      sequencer_start <= next_sequencer_start;
      pulsed_mode_arm <= next_pulsed_mode_arm;
      motor_stop <= next_motor_stop;
      fb2_oe <= next_fb2_oe;
      fb2_out <= next_fb2_out;
      keep_active_input <= next_keep_active;
      watchdog_enable <= next_wd_en;
      watchdog_scale <= next_wd_scale;
      pd_ctl <= next_pd_ctl;
    end
  end

  // command bits and filtered levels go out straight from their flops
  assign watchdog_restart = cmd[CMD_WDOG];
  assign wake_request = cmd[CMD_WAKE];
  assign shutdown_request = cmd[CMD_SHUT];
  assign power_key_input = flt_out[P_KEY];
  assign shutdown_input = flt_out[P_SHUT];
  assign gpi_level = flt_out[P_GPI];
endmodule

// file: verif/pscr_top_asserts.sv
// Purpose: port timing checks of the control register bank
// Assumes: one clock, synchronous reset held by the bench
// Notes: bound into the top; sees its ports only
module pscr_top_asserts import pscr_pkg::*; #(
  parameter int TICK_CYC = 10 // cycles per tick
) (
  input wire logic clk_sys, // clock
  input wire logic sys_rst, // reset
  input wire pscr_pkg::pscr_req_t host_req, // access
  input wire logic write_refused, // refused pulse
  input wire pscr_pkg::pscr_mode_t op_mode, // mode
  input wire logic wakeup_event, // wakeup
  input wire logic ramp_active, // ramp on
  input wire logic ramp_step, // step pulse
  input wire logic sequencer_start, // start pulse
  input wire logic watchdog_enable, // watchdog on
  input wire logic [6:0] watchdog_scale, // multiplier
  input wire logic watchdog_restart, // kick pulse
  input wire logic shutdown_request, // shutdown pending
  input wire pscr_pkg::pscr_pd_t pd_ctl // pd controls
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // command write now; a write in the clear cycle keeps the bit
  wire logic cw = host_req.wr && host_req.addr == OFS_CMD;
  a_kick_set: assert property (cw && host_req.wdata[CMD_WDOG] |=> watchdog_restart)
    else $error("kick missing");
  a_kick_clear: assert property (watchdog_restart && !(cw && host_req.wdata[CMD_WDOG])
    |=> !watchdog_restart) else $error("kick stuck");
  a_refuse_range: assert property (write_refused |-> $past(host_req.wr)
    && $past(host_req.addr) inside {[LOCK_LO:LOCK_HI]}) else $error("bad refusal");
  a_scale_code: assert property ($onehot0(watchdog_scale)
    && (watchdog_enable == (watchdog_scale != 7'h00))) else $error("bad scale");
  a_shut_clear: assert property (op_mode == MODE_RESET && $past(op_mode) != MODE_RESET
    && !(cw && host_req.wdata[CMD_SHUT]) |=> !shutdown_request) else $error("shutdown stuck");
  a_start_cause: assert property (sequencer_start |-> $past(wakeup_event)
    || ($past(op_mode) != MODE_RESET && $past(op_mode, 2) == MODE_RESET))
    else $error("stray start");
  a_pd_idle: assert property ($past(op_mode) != MODE_POWER_DOWN_MODE |-> pd_ctl.domain_ports_en
    && pd_ctl.two_wire_en && pd_ctl.input_pins_en && !pd_ctl.converter_pause)
    else $error("pd control off");
  a_detect_pulse: assert property ($rose(pd_ctl.domain_ports_en)
    |-> ##[0:1] pd_ctl.domain_force_detect) else $error("no force detect");
  a_ramp_idle: assert property (!$past(ramp_active) && !$past(ramp_active, 2)
    |-> !ramp_step) else $error("step while idle");
endmodule
bind pscr_top pscr_top_asserts #(.TICK_CYC(TICK_CYC)) chk_u (.*);

// file: verif/pscr_host_model.sv
// Purpose: host model issuing register reads and writes
// Assumes: one request at a time, launched just after a rising edge
// Notes: idle fields carry inverted values so stale data never matches
module pscr_host_model import pscr_pkg::*; (
  input wire logic clk_sys, // clock
  output pscr_pkg::pscr_req_t host_req, // request
  input wire logic [7:0] host_rdata // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial host_req = '0;
  // write held through its taking edge
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    host_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    host_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  // read; answer taken once its cycle has settled
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    host_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    host_req <= '{1'b0, 1'b0, ~a, 8'hff};
    #1 d = host_rdata;
  endtask
endmodule

// file: verif/pmic_system_control_regs_tb.sv
// Purpose: self-checking bench of the system control register bank
// Assumes: tick shortened to 10 cycles
// Notes: the 16 s wake self-clear is beyond a short run
module pmic_system_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pscr_pkg::*;
  logic clk_sys = 1'b0, sys_rst = 1'b1, slot_zero_entry = 1'b0, wakeup_event = 1'b0;
  logic ramp_active = 1'b0, pd_step_in_range = 1'b0, pd_step_reached = 1'b0, fb3_pin = 1'b1;
  logic fb2_in = 1'b0, power_key_pin = 1'b0, shutdown_pin = 1'b0, gpi_pin = 1'b0;
  logic power_good_status = 1'b0; // regulator good level seen on pin two
  pscr_mode_t op_mode = MODE_RESET;
  pscr_req_t host_req;
  pscr_pd_t pd_ctl;
  logic [7:0] host_rdata, rd_v;
  logic [6:0] watchdog_scale;
  logic write_refused, fb2_out, fb2_oe, default_supply_apply, ramp_step, reload_request;
  logic sequencer_start, power_key_input, shutdown_input, gpi_level, flash_override;
  logic indicator_output_a, indicator_output_b, watchdog_enable, watchdog_restart, motor_stop;
  logic keep_active_input, pulsed_mode_arm, wake_request, shutdown_request;
  int err_total = 0, total_checks = 0, cyc = 0, starts = 0, last = 0, gap = 0;
  logic [8:0] ofs [5] = '{OFS_SEQ, OFS_IND, OFS_LOCK, OFS_CMD, OFS_PDD};
  logic [7:0] wv [5] = '{8'hff, 8'hff, 8'hff, 8'hf8, 8'hff};
  logic [7:0] ev [5] = '{8'hff, 8'hff, WMASK_LOCK, 8'h00, WMASK_PDD};
  logic [8:0] la [4] = '{9'h080, LOCK_LO, LOCK_HI, 9'h121};
  // the four tied inputs feed charger and supply-start flashing, left untested
  pscr_top #(.TICK_CYC(10)) dut_u (.*, .flash_code_from_otp(1'b0), .reset_flash_enable(1'b0),
    .charger_wake_pin(1'b0), .vdd_start_pin(1'b0));
  pscr_host_model host_u (.*);
  always #5 clk_sys = ~clk_sys;
  // cycle count, start count, step spacing, hang limit
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (sequencer_start === 1'b1) begin
      starts <= starts + 1;
    end
    if (ramp_step === 1'b1) begin
      gap <= cyc - last;
      last <= cyc;
    end
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdchk(input logic [8:0] a, input logic [7:0] e);
    host_u.rd(a, rd_v);
    chk("read data", 16'(rd_v), 16'(e));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    tick(12);
    sys_rst <= 1'b0;
    // reset values, then reserved bits and unmapped place
    foreach (ofs[i]) begin
      rdchk(ofs[i], 8'h00);
      host_u.wr(ofs[i], wv[i]);
      rdchk(ofs[i], ev[i]);
    end
    host_u.wr(9'h015, 8'hff);
    rdchk(9'h015, 8'h00);
    // lock set by the loop: window edges
    foreach (la[i]) begin
      host_u.wr(la[i], 8'h5a);
      #1 chk("refused", 16'(write_refused), 16'(i == 1 || i == 2));
    end
    for (int c = 0; c < 8; c++) begin
      host_u.wr(OFS_IND, 8'({c[2:0], c[2:0]}));
      tick(3);
      chk("wd scale", 16'({watchdog_enable, watchdog_scale}),
          c == 0 ? 16'h0000 : 16'h0080 + 16'(1 << (c - 1)));
      chk("flash", 16'(flash_override), 16'(c != 0));
      chk("indicators", 16'({indicator_output_a, indicator_output_b}),
          (c >= 1 && c <= 4) ? 16'h0003 : 16'h0000);
    end
    host_u.wr(OFS_CMD, 8'h01);
    #1 chk("kick", 16'(watchdog_restart), 16'h0001);
    rdchk(OFS_CMD, 8'h00);
    host_u.wr(OFS_SEQ, 8'h00);
    op_mode <= MODE_ACTIVE;
    tick(5);
    chk("no auto start", 16'(starts), 16'h0000);
    wakeup_event <= 1'b1;
    tick(1);
    wakeup_event <= 1'b0;
    tick(2);
    chk("wake start", 16'(starts), 16'h0001);
    host_u.wr(OFS_CMD, 8'h06);
    host_u.wr(OFS_CMD, 8'h00);
    rdchk(OFS_CMD, 8'h06);
    op_mode <= MODE_RESET;
    tick(3);
    chk("shutdown", 16'({wake_request, shutdown_request}), 16'h0002);
    host_u.wr(OFS_LOCK, 8'h08);
    power_good_status <= 1'b1;
    host_u.wr(OFS_SEQ, 8'h98);
    op_mode <= MODE_ACTIVE;
    tick(3);
    chk("auto start", 16'(starts), 16'h0002);
    chk("pin two", 16'({fb2_oe, fb2_out}), 16'h0003);
    op_mode <= MODE_RESET;
    tick(3);
    chk("pulsed arm", 16'(pulsed_mode_arm), 16'h0001);
    for (int v = 0; v < 2; v++) begin
      host_u.wr(OFS_SEQ, 8'(v << 7));
      slot_zero_entry <= 1'b1;
      tick(1);
      slot_zero_entry <= 1'b0;
      chk("default supply", 16'(default_supply_apply), 16'(v));
    end
    host_u.wr(OFS_SEQ, 8'h10);
    host_u.wr(OFS_PDD, 8'h8b);
    for (int s = 0; s < 2; s++) begin
      pd_step_in_range <= 1'(s);
      op_mode <= MODE_POWER_DOWN_MODE;
      tick(4);
      chk("pd wait", 16'(pd_ctl), s == 1 ? 16'h002a : 16'h0004);
      pd_step_reached <= 1'b1;
      tick(1);
      pd_step_reached <= 1'b0;
      tick(2);
      chk("pd off", 16'(pd_ctl), 16'h0004);
      op_mode <= MODE_ACTIVE;
      tick(1);
      chk("reload", 16'(reload_request), 16'h0001);
      tick(2);
      chk("pd on", 16'(pd_ctl), 16'h002a);
    end
    ramp_active <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      host_u.wr(OFS_SEQ, 8'(k << 5));
      tick(4 * (400 >> k));
      chk("ramp gap", 16'(gap), 16'(400 >> k));
    end
    ramp_active <= 1'b0;
    {power_key_pin, shutdown_pin, gpi_pin, fb3_pin, fb2_in} <= 5'b11101;
    host_u.wr(OFS_LOCK, 8'h60);
    tick(8);
    chk("pins", 16'({power_key_input, shutdown_input, gpi_level}), 16'h0007);
    chk("brake keep", 16'({motor_stop, keep_active_input, fb2_oe, fb2_out}), 16'h000c);
    host_u.wr(OFS_SEQ, 8'h01);
    gpi_pin <= 1'b0;
    tick(6);
    chk("filter hold", 16'(gpi_level), 16'h0001);
    tick(24);
    chk("filter pass", 16'(gpi_level), 16'h0000);
    final_report();
  end
endmodule
